// [tb_top.sv]
// Self-checking bench for the timer counter core.
// Assumes sources idle low; inputs change on the falling clock edge.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tb_top;
  logic                  clock, nrst, counter_clear, outputs_hiz, count_wr, overflow_clear;
  logic                  count_down, counting, overflow_flag;
  logic [3:0]            src;
  logic [15:0]           count_wdata, ccr_wdata, count_value, period_latch;
  logic [2:0]            ccr_wr, flag_clear, channel_flag, timer_out, timer_out_oe;
  logic [2:0][1:0]       lls;
  tmr_pkg::tmr_cfg_type  cfg;
  int                    mismatches, num_checks, sel;
  logic [15:0]           maxv [4] = '{`TMR_MAX_8, `TMR_MAX_10, `TMR_MAX_12, `TMR_MAX_16};

  tmr_counter dut_u (.clock(clock), .nrst(nrst), .cfg(cfg), .counter_clear(counter_clear),
    .outputs_hiz(outputs_hiz), .aux_clock(src[0]), .sub_main_clock(src[1]),
    .external_timer_clock(src[2]), .alternate_input_clock(src[3]), .count_wr(count_wr),
    .count_wdata(count_wdata), .ccr_wr(ccr_wr), .ccr_wdata(ccr_wdata),
    .latch_load_select(lls), .flag_clear(flag_clear), .overflow_clear(overflow_clear),
    .count_value(count_value), .count_down(count_down), .counting(counting),
    .period_latch(period_latch), .channel_flag(channel_flag),
    .overflow_flag(overflow_flag), .timer_out(timer_out), .timer_out_oe(timer_out_oe));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // One rising edge of the selected source per count, two cycles each
  task automatic pulse(input int n);
    repeat (n)
    begin
      src[sel] = 1'b1;
      cyc(1);
      src[sel] = 1'b0;
      cyc(1);
    end
  endtask
  task automatic wcnt(input logic [15:0] v);
    count_wdata = v;
    count_wr = 1'b1;
    cyc(1);
    count_wr = 1'b0;
  endtask
  // Immediate load is used, so the latch is valid one cycle later
  task automatic wper(input logic [15:0] v);
    ccr_wdata = v;
    ccr_wr = 3'h1;
    cyc(1);
    ccr_wr = 3'h0;
    cyc(1);
  endtask
  task automatic clr();
    counter_clear = 1'b1;
    cyc(1);
    counter_clear = 1'b0;
    flag_clear = 3'h7;
    overflow_clear = 1'b1;
    cyc(1);
    flag_clear = 3'h0;
    overflow_clear = 1'b0;
  endtask
  task automatic setm(input tmr_pkg::tmr_mode_type m);
    cfg.mode_control = m;
    cyc(2);
  endtask

  task automatic t_len();
    check("reset count", count_value, 16'h0000);
    check("reset flags", 16'({channel_flag, overflow_flag, counting}), 16'h0000);
    for (int l = 0; l < 4; l++)
    begin
      cfg.counter_length = l[1:0];
      clr();
      wcnt(16'hffff);
      check("masked count", count_value, maxv[l]);
    end
  endtask

  task automatic t_up();
    clr();
    wper(16'h0003);
    wcnt(16'h0003);
    cyc(2);
    check("written match flag", 16'(channel_flag[0]), 16'h0000);
    clr();
    setm(tmr_pkg::mode_up);
    pulse(3);
    check("up count", count_value, 16'h0003);
    check("up period flag", 16'({channel_flag[0], overflow_flag}), 16'h0002);
    pulse(1);
    check("up wrap", count_value, 16'h0000);
    check("up overflow", 16'(overflow_flag), 16'h0001);
    setm(tmr_pkg::mode_stop);
    wcnt(16'h0009);
    setm(tmr_pkg::mode_up);
    check("enter up above period", count_value, 16'h0000);
    pulse(2);
    wper(16'h0000);
    pulse(2);
    check("zero period halt", count_value, 16'h0002);
    wper(16'h0006);
    cyc(2);
    pulse(1);
    check("restart count", count_value, 16'h0001);
    pulse(4);
    wper(16'h0002);
    pulse(2);
    check("smaller period rolls", {1'b0, count_value[15:1]}, 16'h0000);
    setm(tmr_pkg::mode_stop);
  endtask

  task automatic t_cont();
    cfg.counter_length = `TMR_LEN_8;
    for (int s = 0; s < 4; s++)
    begin
      cfg.clock_source_select = s[1:0];
      cfg.input_divider = s[1:0];
      sel = s;
      clr();
      setm(tmr_pkg::mode_cont);
      pulse((1 << s) - 1);
      check("divided no count", count_value, 16'h0000);
      pulse(1);
      check("divided count", count_value, 16'h0001);
      setm(tmr_pkg::mode_stop);
    end
    cfg.clock_source_select = `TMR_SRC_AUX;
    cfg.input_divider = `TMR_DIV_1;
    sel = 0;
    clr();
    wcnt(16'h00fe);
    setm(tmr_pkg::mode_cont);
    pulse(1);
    check("at max", 16'({count_value[8:0], overflow_flag}), 16'h01fe);
    pulse(1);
    check("wrap overflow", 16'({count_value[8:0], overflow_flag}), 16'h0001);
    setm(tmr_pkg::mode_stop);
    cfg.counter_length = `TMR_LEN_16;
  endtask

  task automatic t_updn();
    logic t0;
    clr();
    wper(16'h0003);
    setm(tmr_pkg::mode_updown);
    t0 = timer_out[0];
    pulse(3);
    check("updown period flag", 16'({channel_flag[0], overflow_flag}), 16'h0002);
    check("period toggle", 16'(timer_out[0]), 16'(!t0));
    pulse(1);
    setm(tmr_pkg::mode_stop);
    pulse(1);
    setm(tmr_pkg::mode_updown);
    pulse(1);
    check("resumed down", 16'({count_value[3:0], count_down}), 16'h0003);
    pulse(1);
    check("down overflow", 16'({count_value[3:0], overflow_flag}), 16'h0001);
    pulse(4);
    check("turned down", 16'(count_down), 16'h0001);
    clr();
    check("clear direction", 16'({count_value[3:0], count_down}), 16'h0000);
    setm(tmr_pkg::mode_stop);
    outputs_hiz = 1'b1;
    cyc(1);
    check("outputs released", 16'(timer_out_oe), 16'h0000);
    outputs_hiz = 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the under two hundred cycles the tests need
  initial
  begin
    repeat (6000) @(posedge clock);
    mismatches++;
    test_done();
  end

  initial
  begin
    {nrst, counter_clear, outputs_hiz, count_wr, overflow_clear} = 5'h00;
    {src, count_wdata, ccr_wdata, ccr_wr, flag_clear, lls} = '0;
    cfg = '{tmr_pkg::mode_stop, `TMR_LEN_16, `TMR_SRC_AUX, `TMR_DIV_1};
    sel = 0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    t_len();
    t_up();
    t_cont();
    t_updn();
    test_done();
  end
endmodule

// [tmr_channel.sv]
// One compare channel: buffered compare latch, flag and output.
// Assumes count state arrives as tmr_cnt_type from the counter.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_channel (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // Count state and mode
  input  tmr_pkg::tmr_cnt_type       cnt,
  input  wire logic                  updown,
  input  wire logic                  period_hit,
  // Software side
  input  wire logic [1:0]            latch_load_select,
  input  wire logic                  ccr_wr,
  input  wire logic [`TMR_WIDTH-1:0] ccr_wdata,
  input  wire logic                  flag_clear,
  input  wire logic                  outputs_hiz,
  // Results
  output logic [`TMR_WIDTH-1:0]      compare_latch,
  output logic                       equal,
  output logic                       channel_flag,
  output logic                       timer_out,
  output logic                       timer_out_oe
);

  logic [`TMR_WIDTH-1:0] ccr_q;    // Software-written buffer
  logic                  pend_q;   // Buffer awaits transfer
  logic                  zero_evt; // Counter counted to zero
  logic                  load_evt; // Buffer moves into latch

  // Compare only on counted values, never on writes
  assign equal    = cnt.counted && (cnt.count_value == compare_latch);
  assign zero_evt = cnt.counted && (cnt.count_value == `TMR_ZERO);

  // Load event per select code
  always_comb
  begin
    case (latch_load_select)
      `TMR_LOAD_NOW:      load_evt = ccr_wr;
      `TMR_LOAD_ZERO:     load_evt = pend_q && zero_evt;
      `TMR_LOAD_ZERO_PER: load_evt = pend_q && (zero_evt || (updown && period_hit));
      default:            load_evt = pend_q && equal;
    endcase
  end

  // Buffer and pending mark; a fresh write outranks a transfer
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ccr_q  <= `TMR_ZERO;
      pend_q <= 1'b0;
    end
    else if (ccr_wr)
    begin
      ccr_q  <= ccr_wdata;
      pend_q <= (latch_load_select != `TMR_LOAD_NOW);
    end
    else if (load_evt)
      pend_q <= 1'b0;
  end

  // Compare latch
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      compare_latch <= `TMR_ZERO;
    else if (load_evt)
      compare_latch <= (latch_load_select == `TMR_LOAD_NOW) ? ccr_wdata : ccr_q;
  end

  // Sticky flag; the set wins over a same-cycle clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      channel_flag <= 1'b0;
    else if (equal)
      channel_flag <= 1'b1;
    else if (flag_clear)
      channel_flag <= 1'b0;
  end

  // Output toggles on each match
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      timer_out <= 1'b0;
    else if (equal)
      timer_out <= ~timer_out;
  end

  // Driven unless software asks for high impedance
  assign timer_out_oe = !outputs_hiz;

endmodule

// [tmr_counter.sv]
// Core counter of the general-purpose timer: length, modes, flags.
// Assumes all inputs are synchronous to clock, and that software
// stops the counter before changing cfg (flags and clear excepted).
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_counter #(
  parameter int CHANNELS = 3  // Three or seven compare channels
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         nrst,

  // Configuration
  input  tmr_pkg::tmr_cfg_type              cfg,
  input  wire logic                         counter_clear,
  input  wire logic                         outputs_hiz,

  // Timer clock sources
  input  wire logic                         aux_clock,
  input  wire logic                         sub_main_clock,
  input  wire logic                         external_timer_clock,
  input  wire logic                         alternate_input_clock,

  // Count register write
  input  wire logic                         count_wr,
  input  wire logic [`TMR_WIDTH-1:0]        count_wdata,

  // Capture/compare register writes; channel 0 is the period
  input  wire logic [CHANNELS-1:0]          ccr_wr,
  input  wire logic [`TMR_WIDTH-1:0]        ccr_wdata,
  input  wire logic [CHANNELS-1:0][1:0]     latch_load_select,

  // Flag clears
  input  wire logic [CHANNELS-1:0]          flag_clear,
  input  wire logic                         overflow_clear,

  // Count state
  output logic [`TMR_WIDTH-1:0]             count_value,
  output logic                              count_down,
  output logic                              counting,
  output logic [`TMR_WIDTH-1:0]             period_latch,

  // Flags
  output logic [CHANNELS-1:0]               channel_flag,
  output logic                              overflow_flag,

  // Timer outputs
  output logic [CHANNELS-1:0]               timer_out,
  output logic [CHANNELS-1:0]               timer_out_oe
);

  // Count state
  logic [`TMR_WIDTH-1:0] count_q;       // Count register
  logic [`TMR_WIDTH-1:0] count_d;       // Count after one tick
  logic                  down_q;        // Latched direction
  logic                  down_d;        // Direction after one tick
  logic                  counted_q;     // Count changed by counting
  logic                  wrap;          // This tick is an overflow
  logic                  step;          // Mode lets the tick count

  // Configuration decode
  logic [`TMR_WIDTH-1:0] max_count;     // Maximum of selected length
  logic [`TMR_WIDTH-1:0] period;        // Channel 0 latch
  logic                  period_mode;   // Up or up/down
  logic                  period_zero;   // Zero period halts
  logic                  period_zero_q; // Period was zero
  logic                  restart;       // Zero-to-nonzero period load

  tmr_pkg::tmr_mode_type mode_q;        // Mode seen last cycle
  logic                  enter_up;      // Up entered above period

  // Clock path
  logic                  tick;          // Divided timer clock event

  // Channel wiring
  tmr_pkg::tmr_cnt_type  cnt_bus;
  logic [`TMR_WIDTH-1:0] latch_w [CHANNELS];
  logic [CHANNELS-1:0]   equal_w;

  // Selected length maximum
  always_comb
  begin
    case (cfg.counter_length)
      `TMR_LEN_8:  max_count = `TMR_MAX_8;
      `TMR_LEN_10: max_count = `TMR_MAX_10;
      `TMR_LEN_12: max_count = `TMR_MAX_12;
      default:     max_count = `TMR_MAX_16;
    endcase
  end

  // Period decode
  assign period      = latch_w[0];
  assign period_mode = (cfg.mode_control == tmr_pkg::mode_up) ||
                       (cfg.mode_control == tmr_pkg::mode_updown);

  assign period_zero = period_mode && (period == `TMR_ZERO);

  // Restart once a nonzero period follows a zero one
  assign restart  = period_mode && period_zero_q && (period != `TMR_ZERO);

  // Switching into up mode above the period restarts at once
  assign enter_up = (cfg.mode_control == tmr_pkg::mode_up) &&
                    (mode_q != tmr_pkg::mode_up) &&
                    (count_q > period);

  // Next count for one tick, per mode
  always_comb
  begin
    count_d = count_q;
    down_d  = down_q;
    wrap    = 1'b0;
    step    = 1'b0;

    case (cfg.mode_control)
      tmr_pkg::mode_up:
      begin
        if (!period_zero)
        begin
          step = 1'b1;

          if (count_q == period)
          begin
            // Period reached: roll over and flag the overflow
            count_d = `TMR_ZERO;
            wrap    = 1'b1;
          end

          else if (count_q > period)
          begin
            // Period shrank below count: roll with no overflow
            count_d = `TMR_ZERO;
          end
          else
          begin
            count_d = count_q + `TMR_ONE;
          end
        end
      end

      tmr_pkg::mode_cont:
      begin
        step = 1'b1;
        if (count_q >= max_count)
        begin
          // Wrap uses the selected length only
          count_d = `TMR_ZERO;
          wrap    = (count_q == max_count);
        end
        else
        begin
          count_d = count_q + `TMR_ONE;
        end
      end

      tmr_pkg::mode_updown:
      begin
        if (!period_zero)
        begin
          step = 1'b1;

          if (period > max_count)
          begin
            // Period out of reach: behave as continuous
            if (count_q >= max_count)
            begin
              count_d = `TMR_ZERO;
              wrap    = (count_q == max_count);
            end
            else
            begin
              count_d = count_q + `TMR_ONE;
            end
          end

          else if (!down_q)
          begin
            if (count_q >= period)
            begin
              // Turn at the period; a late smaller period turns too
              down_d  = 1'b1;
              count_d = count_q - `TMR_ONE;
            end
            else
            begin
              count_d = count_q + `TMR_ONE;
            end
          end

          else if (count_q == `TMR_ZERO)
          begin
            // Written zero while going down: turn up
            down_d  = 1'b0;
            count_d = `TMR_ONE;
          end
          else
          begin
            count_d = count_q - `TMR_ONE;
            if (count_q == `TMR_ONE)
            begin
              // Bottom reached by counting down
              wrap   = 1'b1;
              down_d = 1'b0;
            end
          end
        end
      end

      default:
      begin
        // Stop: hold count and direction
        count_d = count_q;
      end
    endcase
  end

  // Count register; clear beats write beats counting
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      count_q <= `TMR_ZERO;
    else if (counter_clear)
      count_q <= `TMR_ZERO;
    else if (count_wr)
      count_q <= count_wdata & max_count;
    else if (restart || enter_up)
      count_q <= `TMR_ZERO;
    else if (tick && step)
      count_q <= count_d & max_count;
    else
      count_q <= count_q & max_count;
  end

  // Direction; latched across stops, reset only by clear or restart
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      down_q <= 1'b0;
    else if (counter_clear || restart)
      down_q <= 1'b0;
    // Writes and mode entry keep the direction
    else if (tick && step && !count_wr && !enter_up)
      down_q <= down_d;
  end

  // Marks counted values so writes never trigger compares
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      counted_q <= 1'b0;
    else
      counted_q <= tick && step && !counter_clear && !count_wr &&
                   !restart && !enter_up;
  end

  // Overflow flag is sticky; the set wins over a same-cycle clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      overflow_flag <= 1'b0;
    else if (tick && step && wrap && !counter_clear && !count_wr &&
             !restart && !enter_up)
      overflow_flag <= 1'b1;

    else if (overflow_clear)
      overflow_flag <= 1'b0;
  end

  // History for the restart and mode-entry detectors
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      period_zero_q <= 1'b0;
      mode_q        <= tmr_pkg::mode_stop;
    end
    else
    begin
      period_zero_q <= period_zero;

      mode_q        <= cfg.mode_control;
    end
  end

  // Running status for software
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      counting <= 1'b0;
    else
      counting <= (cfg.mode_control != tmr_pkg::mode_stop) && !period_zero;
  end

  // Published state
  assign count_value  = count_q;
  assign count_down   = down_q;
  assign period_latch = period;

  assign cnt_bus      = '{count_value: count_q, counted: counted_q, down: down_q};

  // Clock source mux and divider
  tmr_prescale u_prescale (
    .clock               (clock),
    .nrst                (nrst),
    .sources             ({alternate_input_clock, external_timer_clock,
                           sub_main_clock, aux_clock}),

    .clock_source_select (cfg.clock_source_select),
    .input_divider       (cfg.input_divider),
    .counter_clear       (counter_clear),
    .tick                (tick)
  );

  // Compare channels; channel 0 doubles as the period register
  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    // Every channel sees the same counted state
    tmr_channel u_chan (
      .clock             (clock),
      .nrst              (nrst),
      .cnt               (cnt_bus),
      .updown            (cfg.mode_control == tmr_pkg::mode_updown),
      .period_hit        (equal_w[0]),

      .latch_load_select (latch_load_select[i]),
      .ccr_wr            (ccr_wr[i]),
      .ccr_wdata         (ccr_wdata),
      .flag_clear        (flag_clear[i]),
      .outputs_hiz       (outputs_hiz),

      .compare_latch     (latch_w[i]),
      .equal             (equal_w[i]),
      .channel_flag      (channel_flag[i]),
      .timer_out         (timer_out[i]),
      .timer_out_oe      (timer_out_oe[i])
    );
  end

endmodule

// [tmr_counter_sva.sv]
// Port-level assertions for the timer counter core.
// Assumes binding onto tmr_counter; all checks live in the one clock domain.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_counter_sva #(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  nrst,
  // Control inputs
  input tmr_pkg::tmr_cfg_type       cfg,
  input wire logic                  counter_clear,
  input wire logic                  outputs_hiz,
  input wire logic                  count_wr,
  input wire logic [15:0]           count_wdata,
  input wire logic [CHANNELS-1:0]   ccr_wr,
  // Observed outputs
  input wire logic [15:0]           count_value,
  input wire logic                  count_down,
  input wire logic [15:0]           period_latch,
  input wire logic [CHANNELS-1:0]   channel_flag,
  input wire logic                  overflow_flag,
  input wire logic [CHANNELS-1:0]   timer_out_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Maximum count of the selected length
  function automatic logic [15:0] mx(input logic [1:0] l);
    case (l)
      `TMR_LEN_8:  mx = `TMR_MAX_8;
      `TMR_LEN_10: mx = `TMR_MAX_10;
      `TMR_LEN_12: mx = `TMR_MAX_12;
      default:     mx = `TMR_MAX_16;
    endcase
  endfunction

  wire logic [15:0] max_w = mx(cfg.counter_length);  // Current length maximum
  wire logic        quiet = !count_wr && !counter_clear;  // No software override

  property p_write;
    count_wr && !counter_clear |=> count_value == $past(count_wdata & max_w);
  endproperty
  a_write: assert property (p_write) else $error("count write not applied");
  property p_clear;
    counter_clear |=> count_value == `TMR_ZERO && !count_down;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_stop;
    cfg.mode_control == tmr_pkg::mode_stop && quiet |=> $stable(count_value);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved in stop");
  property p_mask;
    $stable(cfg.counter_length) |=> (count_value & ~$past(max_w)) == `TMR_ZERO;
  endproperty
  a_mask: assert property (p_mask) else $error("bits above length");
  property p_ovf;
    $rose(overflow_flag) |-> count_value == `TMR_ZERO && $past(count_value) != `TMR_ZERO;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without wrap");
  property p_chf;
    $rose(channel_flag[0]) |-> $past(count_value) == $past(period_latch);
  endproperty
  a_chf: assert property (p_chf) else $error("period flag without match");
  // Continuous mode holds or steps by one within the length
  property p_cont;
    cfg.mode_control == tmr_pkg::mode_cont && $stable(cfg) && quiet |=>
      count_value == $past(count_value) ||
      count_value == (($past(count_value) + 16'h0001) & $past(max_w));
  endproperty
  a_cont: assert property (p_cont) else $error("bad continuous step");
  // Up mode leaves the period value only towards zero
  property p_upwrap;
    cfg.mode_control == tmr_pkg::mode_up && $stable(cfg) && quiet && !ccr_wr[0] &&
      period_latch != `TMR_ZERO && count_value == period_latch |=>
      count_value == $past(count_value) || count_value == `TMR_ZERO;
  endproperty
  a_upwrap: assert property (p_upwrap) else $error("bad up wrap");
  property p_oe;
    timer_out_oe == {CHANNELS{!outputs_hiz}};
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");

  // Main scenarios reached
  c_ovf: cover property ($rose(overflow_flag));
  c_chf: cover property ($rose(channel_flag[0]));
  c_down: cover property ($rose(count_down));
endmodule

bind tmr_counter tmr_counter_sva #(.CHANNELS(CHANNELS)) sva_u (.clock(clock), .nrst(nrst),
  .cfg(cfg), .counter_clear(counter_clear), .outputs_hiz(outputs_hiz), .count_wr(count_wr),
  .count_wdata(count_wdata), .ccr_wr(ccr_wr), .count_value(count_value),
  .count_down(count_down), .period_latch(period_latch), .channel_flag(channel_flag),
  .overflow_flag(overflow_flag), .timer_out_oe(timer_out_oe));

// [tmr_defs.svh]
// Constants shared by the configurable-length timer counter.
// Assumes it is included by bare name from the package and from the modules.
// Functional notes
// - Count steps on each selected timer clock
// - Clear zeroes count, prescaler and direction
// - Software count write takes effect at once
// - Only counted values set flags, not writes
// - Length select gives 8/10/12/16 bit maximum
// - Written count is masked to selected length
// - Four clock sources are selectable
// - Prescaler divides by 1, 2, 4 or 8
// - Counts only with nonzero mode and clock
// - Zero period halts; nonzero restarts from zero
// - Mode codes: stop, up, continuous, up/down
// - Up mode wraps at period, period+1 counts
// - Entering up above period restarts at zero
// - Up mode: period flag, then overflow flag
// - Immediate smaller period rolls counter to zero in up mode; up/down turns down
// - Continuous wraps at maximum; channel 0 plain
// - Continuous sets overflow at maximum-to-zero wrap
// - Three or seven compare channels with flags
// - All timer outputs can be tri-stated
// - Up/down: period flag up, overflow at 1-to-0
// - Direction latched; only clear or restart resets it
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// Counter width and well-known count values
`define TMR_WIDTH         16
`define TMR_ZERO          16'h0000
`define TMR_ONE           16'h0001

// Mode control codes
`define TMR_MODE_STOP     2'h0
`define TMR_MODE_UP       2'h1
`define TMR_MODE_CONT     2'h2
`define TMR_MODE_UPDN     2'h3

// Counter length codes and their maxima
`define TMR_LEN_8         2'h0
`define TMR_LEN_10        2'h1
`define TMR_LEN_12        2'h2
`define TMR_LEN_16        2'h3
`define TMR_MAX_8         16'h00ff
`define TMR_MAX_10        16'h03ff
`define TMR_MAX_12        16'h0fff
`define TMR_MAX_16        16'hffff

// Clock source codes
`define TMR_SRC_AUX       2'h0
`define TMR_SRC_SUBMAIN   2'h1
`define TMR_SRC_EXT       2'h2
`define TMR_SRC_ALT       2'h3

// Input divider codes and terminal prescaler counts
`define TMR_DIV_1         2'h0
`define TMR_DIV_2         2'h1
`define TMR_DIV_4         2'h2
`define TMR_DIV_8         2'h3
`define TMR_DIVEND_1      3'h0
`define TMR_DIVEND_2      3'h1
`define TMR_DIVEND_4      3'h3
`define TMR_DIVEND_8      3'h7

// Compare latch load events
`define TMR_LOAD_NOW      2'h0
`define TMR_LOAD_ZERO     2'h1
`define TMR_LOAD_ZERO_PER 2'h2
`define TMR_LOAD_OLD      2'h3

`endif

// [tmr_pkg.sv]
// Types of the configurable-length timer counter.
// Assumes tmr_defs.svh is on the include path.
`include "tmr_defs.svh"

package tmr_pkg;

  // Operating modes
  typedef enum logic [1:0] {
    mode_stop   = `TMR_MODE_STOP,
    mode_up     = `TMR_MODE_UP,
    mode_cont   = `TMR_MODE_CONT,
    mode_updown = `TMR_MODE_UPDN
  } tmr_mode_type;

  // Static configuration, changed only while stopped
  typedef struct packed {
    tmr_mode_type mode_control;
    logic [1:0]   counter_length;
    logic [1:0]   clock_source_select;
    logic [1:0]   input_divider;
  } tmr_cfg_type;

  // Count state seen by the compare channels
  typedef struct packed {
    logic [`TMR_WIDTH-1:0] count_value;
    logic                  counted;
    logic                  down;
  } tmr_cnt_type;

endpackage

// [tmr_prescale.sv]
// Timer clock source selection and input divider.
// Assumes the four sources are levels synchronous to clock.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_prescale (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Timer clock sources, indexed by source code
  input  wire logic [3:0] sources,
  // Selection and clear
  input  wire logic [1:0] clock_source_select,
  input  wire logic [1:0] input_divider,
  input  wire logic       counter_clear,
  // One-cycle count enable
  output logic            tick
);

  logic       src_now;   // Selected source level
  logic       src_q;     // Previous source level
  logic       edge_hit;  // Rising edge of selected source
  logic [2:0] div_q;     // Prescaler count
  logic [2:0] div_end;   // Terminal prescaler count

  // Source mux; switching sources while running may fake one edge
  assign src_now  = sources[clock_source_select];
  assign edge_hit = src_now & ~src_q;

  // Terminal count per divider code
  always_comb
  begin
    case (input_divider)
      `TMR_DIV_1: div_end = `TMR_DIVEND_1;
      `TMR_DIV_2: div_end = `TMR_DIVEND_2;
      `TMR_DIV_4: div_end = `TMR_DIVEND_4;
      default:    div_end = `TMR_DIVEND_8;
    endcase
  end

  // Edge history; reset high so a high source gives no edge at start
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      src_q <= 1'b1;
    else
      src_q <= src_now;
  end

  // Prescaler, cleared together with the count
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      div_q <= 3'h0;
    else if (counter_clear)
      div_q <= 3'h0;
    else if (edge_hit)
      div_q <= (div_q >= div_end) ? 3'h0 : div_q + 3'h1;
  end

  // A tick only exists while the selected source toggles
  assign tick = edge_hit && (div_q >= div_end) && !counter_clear;

endmodule
